// File: hw/uls_pkg.sv
// Constants and types for the line status / scratch block
package uls_pkg;
  localparam int          ADDR_W          = 32;
  localparam int          DATA_W          = 32;
  // Register byte addresses
  localparam logic [31:0] OFS_RX_BUF      = 32'he000c000;
  localparam logic [31:0] OFS_TX_HOLD     = 32'he000c000;
  localparam logic [31:0] OFS_FIFO_CTRL   = 32'he000c008;
  localparam logic [31:0] OFS_LINE_CTRL   = 32'he000c00c;
  localparam logic [31:0] OFS_LINE_STATUS = 32'he000c014;
  localparam logic [31:0] OFS_SCRATCH     = 32'he000c01c;
  localparam logic [31:0] OFS_INT_STATUS  = 32'he000c030;
  localparam logic [31:0] OFS_INT_CLEAR   = 32'he000c034;
  localparam logic [31:0] OFS_INT_ENABLE  = 32'he000c038;
  // Line status fields
  localparam int          LSR_READY       = 0;
  localparam int          LSR_PE          = 2;
  localparam int          LSR_FRAMING     = 3;
  localparam int          LSR_BREAK       = 4;
  localparam int          LSR_HOLD_EMPTY  = 5;
  localparam int          LSR_TX_IDLE     = 6;
  localparam int          LSR_FIFO_ERR    = 7;
  // Control fields
  localparam int          FCR_EN          = 0;
  localparam int          LCR_PEN         = 0;
  localparam int          LCR_EVEN        = 1;
  // Interrupt events
  localparam int          EV_W            = 4;
  localparam int          EV_RX           = 0;
  localparam int          EV_FRAMING      = 1;
  localparam int          EV_BREAK        = 2;
  localparam int          EV_HOLD_EMPTY   = 3;
  // Reset values
  localparam logic [7:0]  SCRATCH_RST     = 8'h00;
  localparam logic [1:0]  LCR_RST         = 2'h0;
  // Timing
  localparam int          CLK_HZ          = 100000000;
  localparam int          BAUD_HZ         = 115200;
  localparam int          BIT_CYC         = CLK_HZ / BAUD_HZ;
  localparam int          CHAR_BITS       = 8;
  localparam int          TX_FRAME        = 10;

  typedef enum logic [2:0] {
    ULS_RX_IDLE  = 3'b000,
    ULS_RX_START = 3'b001,
    ULS_RX_DATA  = 3'b011,
    ULS_RX_PAR   = 3'b010,
    ULS_RX_STOP  = 3'b110,
    ULS_RX_BRK   = 3'b111
  } uls_rx_state_t;
endpackage

// File: hw/uls_top.sv
// Serial port receiver/transmitter with upper line status and scratch byte
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
//
// Contract
// - Flag framing error when a received stop bit samples low.
// - Reading line status clears the framing error flag.
// - After framing error, take the low stop bit as next start bit.
// - Framing error flag belongs to the receive FIFO head character.
// - Flag break when line stays low a whole character time.
// - After break, receiver idles until the line returns high.
// - Line status read clears break flag; break belongs to FIFO head.
// - Error flag timing follows FIFO enabled or disabled operation.
// - Holding-empty sets on empty holding reg, clears on write, resets one.
// - Transmitter idle only while holding and shift regs empty; resets one.
// - FIFO error sets when an erroneous character enters the receive buffer.
// - FIFO error clears on status read only if no errors remain.
// - FIFO error reads zero while FIFO enable is zero.
// - Eight-bit scratch register, reset 0x00, freely read and written.
// - Scratch accesses raise no interrupt and set no status.
// - Line status read-only; data ready while receive FIFO non-empty.
module uls_top #(
  parameter int BIT_CYC    = uls_pkg::BIT_CYC,
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                       clk,
  input  wire logic                       resetn,
  // Register port
  input  wire logic [uls_pkg::ADDR_W-1:0] addr,
  input  wire logic [uls_pkg::DATA_W-1:0] wr_data,
  input  wire logic                       wr_en,
  input  wire logic                       rd_en,
  output logic      [uls_pkg::DATA_W-1:0] rd_data,
  // Serial pins
  input  wire logic                       serial_rx_pin,
  output logic                            serial_tx_pin,
  // Interrupt
  output logic                            irq
);
  import uls_pkg::*;

  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int CW    = $clog2(BIT_CYC + 1);
  localparam logic [CW-1:0]  BIT_LAST  = CW'(BIT_CYC - 1);
  localparam logic [CW-1:0]  HALF_LAST = CW'(BIT_CYC / 2 - 1);
  localparam logic [PTR_W:0] DEPTH_C   = (PTR_W+1)'(FIFO_DEPTH);

  // Entry layout: parity, break and framing marks, then data
  typedef struct packed {
    logic       pe;
    logic       brk;
    logic       frm;
    logic [7:0] data;
  } uls_entry_t;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [31:0]       ofs);
    return a == ofs;
  endfunction

  function automatic logic has_err(input uls_entry_t e);
    return e.pe | e.brk | e.frm;
  endfunction

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  logic wr_thr, wr_fcr, wr_lcr, wr_scr, wr_iclr, wr_ien, wr_lsr;
  logic rd_rbr, rd_lsr;

  assign wr_thr  = wr_en && hit(addr, OFS_TX_HOLD);
  assign wr_fcr  = wr_en && hit(addr, OFS_FIFO_CTRL);
  assign wr_lcr  = wr_en && hit(addr, OFS_LINE_CTRL);
  assign wr_scr  = wr_en && hit(addr, OFS_SCRATCH);
  assign wr_iclr = wr_en && hit(addr, OFS_INT_CLEAR);
  assign wr_ien  = wr_en && hit(addr, OFS_INT_ENABLE);
  assign wr_lsr  = wr_en && hit(addr, OFS_LINE_STATUS);
  assign rd_rbr  = rd_en && hit(addr, OFS_RX_BUF);
  assign rd_lsr  = rd_en && hit(addr, OFS_LINE_STATUS);

  logic       fifo_en;
  logic [1:0] line_ctrl;
  logic [7:0] scratch_pad;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fifo_en   <= 1'b0;
      line_ctrl <= LCR_RST;
    end else begin
      if (wr_fcr) begin
        fifo_en <= wr_data[FCR_EN];
      end
      if (wr_lcr) begin
        line_ctrl <= wr_data[1:0];
      end
    end
  end

  // Scratch byte touches nothing else in the block
  always_ff @(posedge clk) begin
    if (!resetn) begin
      scratch_pad <= SCRATCH_RST;
    end else if (wr_scr) begin
      scratch_pad <= wr_data[7:0];
    end
  end

  // --------------------------------------------------------------
  // Receive line synchroniser
  // --------------------------------------------------------------
  logic rx_meta, rx_s;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_meta <= 1'b1;
      rx_s    <= 1'b1;
    end else begin
      rx_meta <= serial_rx_pin;
      rx_s    <= rx_meta;
    end
  end

  // --------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------
  uls_rx_state_t rx_state;
  logic [CW-1:0] rx_cnt;
  logic [2:0]    rx_idx;
  logic [7:0]    rx_shift;
  logic          rx_par;
  logic          rx_zero;
  logic          rx_push;
  uls_entry_t    rx_entry;
  logic          exp_par;
  logic          stop_tick;

  assign exp_par   = line_ctrl[LCR_EVEN] ? ^rx_shift : ~^rx_shift;
  assign stop_tick = rx_state == ULS_RX_STOP && rx_cnt == BIT_LAST;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rx_state <= ULS_RX_IDLE;
      rx_cnt   <= '0;
      rx_idx   <= '0;
      rx_shift <= '0;
      rx_par   <= 1'b0;
      rx_zero  <= 1'b0;
      rx_push  <= 1'b0;
      rx_entry <= '0;
    end else begin
      rx_push <= 1'b0;
      rx_cnt  <= rx_cnt + CW'(1);
      unique case (rx_state)
        ULS_RX_IDLE: begin
          rx_cnt <= '0;
          if (!rx_s) begin
            rx_state <= ULS_RX_START;
          end
        end
        ULS_RX_START: begin
          if (rx_cnt == HALF_LAST) begin
            rx_cnt   <= '0;
            rx_idx   <= '0;
            rx_zero  <= 1'b1;
            // Glitch shorter than half a bit is dropped
            rx_state <= rx_s ? ULS_RX_IDLE : ULS_RX_DATA;
          end
        end
        ULS_RX_DATA: begin
          if (rx_cnt == BIT_LAST) begin
            rx_cnt   <= '0;
            rx_shift <= {rx_s, rx_shift[7:1]};
            rx_zero  <= rx_zero & ~rx_s;
            rx_idx   <= rx_idx + 3'h1;
            if (rx_idx == 3'(CHAR_BITS - 1)) begin
              rx_state <= line_ctrl[LCR_PEN] ? ULS_RX_PAR : ULS_RX_STOP;
            end
          end
        end
        ULS_RX_PAR: begin
          if (rx_cnt == BIT_LAST) begin
            rx_cnt   <= '0;
            rx_par   <= rx_s;
            rx_zero  <= rx_zero & ~rx_s;
            rx_state <= ULS_RX_STOP;
          end
        end
        ULS_RX_STOP: begin
          if (rx_cnt == BIT_LAST) begin
            rx_cnt        <= '0;
            rx_push       <= 1'b1;
            rx_entry.data <= rx_shift;
            rx_entry.pe   <= line_ctrl[LCR_PEN] & (rx_par != exp_par);
            rx_entry.frm  <= ~rx_s;
            rx_entry.brk  <= ~rx_s & rx_zero;
            if (rx_s) begin
              rx_state <= ULS_RX_IDLE;
            end else if (rx_zero) begin
              rx_state <= ULS_RX_BRK;
            end else begin
              // Mid bad stop bit is taken as mid start bit
              rx_idx   <= '0;
              rx_zero  <= 1'b1;
              rx_state <= ULS_RX_DATA;
            end
          end
        end
        ULS_RX_BRK: begin
          if (rx_s) begin
            rx_state <= ULS_RX_IDLE;
          end
        end
        default: begin
          rx_state <= ULS_RX_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Receive FIFO; depth one when disabled
  // --------------------------------------------------------------
  uls_entry_t     mem [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr;
  logic [PTR_W:0] count, next_count, err_cnt;
  logic           do_push, do_pop, head_load;
  uls_entry_t     head;

  assign head       = mem[rd_ptr];
  assign do_pop     = rd_rbr && count != '0;
  // Overrun is handled outside this block: a full FIFO drops
  assign do_push    = rx_push && count < (fifo_en ? DEPTH_C : (PTR_W+1)'(1));
  assign next_count = count + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_pop);

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wr_ptr] <= rx_entry;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || wr_fcr) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      err_cnt   <= '0;
      head_load <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + PTR_W'(1);
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + PTR_W'(1);
      end
      count     <= next_count;
      err_cnt   <= err_cnt + (PTR_W+1)'(do_push && has_err(rx_entry))
                           - (PTR_W+1)'(do_pop && has_err(head));
      // A new character reaches the head next cycle
      head_load <= next_count != '0 && (count == '0 || do_pop);
    end
  end

  // --------------------------------------------------------------
  // Head error flags, cleared by status read, and FIFO error flag, cleared by status read once no errors remain; set wins
  // --------------------------------------------------------------
  logic framing_error_flag, break_detect_flag, pe_flag, rx_fifo_error_flag;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      framing_error_flag <= 1'b0;
      break_detect_flag  <= 1'b0;
      pe_flag            <= 1'b0;
    end else if (head_load) begin
      framing_error_flag <= head.frm | (framing_error_flag & ~rd_lsr);
      break_detect_flag  <= head.brk | (break_detect_flag & ~rd_lsr);
      pe_flag            <= head.pe | (pe_flag & ~rd_lsr);
    end else if (rd_lsr) begin
      framing_error_flag <= 1'b0;
      break_detect_flag  <= 1'b0;
      pe_flag            <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || wr_fcr) begin
      rx_fifo_error_flag <= 1'b0;
    end else if (do_push && has_err(rx_entry)) begin
      rx_fifo_error_flag <= 1'b1;
    end else if (rd_lsr && err_cnt == '0) begin
      rx_fifo_error_flag <= 1'b0;
    end
  end

  // --------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------
  logic [7:0]          tx_hold;
  logic                thr_full;
  logic [TX_FRAME-1:0] tx_shift;
  logic                tx_busy;
  logic [CW-1:0]       tx_cnt;
  logic [3:0]          tx_nb;
  logic                tx_load;

  assign tx_load = thr_full && !tx_busy;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_hold  <= '0;
      thr_full <= 1'b0;
    end else if (wr_thr) begin
      tx_hold  <= wr_data[7:0];
      thr_full <= 1'b1;
    end else if (tx_load) begin
      thr_full <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      tx_shift      <= '1;
      tx_busy       <= 1'b0;
      tx_cnt        <= '0;
      tx_nb         <= '0;
      serial_tx_pin <= 1'b1;
    end else if (tx_load) begin
      tx_shift <= {1'b1, tx_hold, 1'b0};
      tx_busy  <= 1'b1;
      tx_cnt   <= '0;
      tx_nb    <= '0;
    end else if (tx_busy) begin
      serial_tx_pin <= tx_shift[0];
      tx_cnt        <= tx_cnt + CW'(1);
      if (tx_cnt == BIT_LAST) begin
        tx_cnt   <= '0;
        tx_shift <= {1'b1, tx_shift[TX_FRAME-1:1]};
        tx_nb    <= tx_nb + 4'h1;
        if (tx_nb == 4'(TX_FRAME - 1)) begin
          tx_busy <= 1'b0;
        end
      end
    end else begin
      serial_tx_pin <= 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Line status value; no write path exists
  // --------------------------------------------------------------
  logic [7:0] line_status;

  always_comb begin
    line_status                 = '0;
    line_status[LSR_READY]      = count != '0;
    line_status[LSR_PE]         = pe_flag;
    line_status[LSR_FRAMING]    = framing_error_flag;
    line_status[LSR_BREAK]      = break_detect_flag;
    line_status[LSR_HOLD_EMPTY] = !thr_full;
    line_status[LSR_TX_IDLE]    = !thr_full && !tx_busy;
    line_status[LSR_FIFO_ERR]   = rx_fifo_error_flag && fifo_en;
  end

  // --------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------
  logic [EV_W-1:0] int_status, int_enable, events;

  always_comb begin
    events                = '0;
    events[EV_RX]         = do_push;
    events[EV_FRAMING]    = do_push && rx_entry.frm;
    events[EV_BREAK]      = do_push && rx_entry.brk;
    events[EV_HOLD_EMPTY] = tx_load;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      int_status <= '0;
      int_enable <= '0;
      irq        <= 1'b0;
    end else begin
      // Set wins over a clear in the same cycle
      int_status <= events | (int_status & ~(wr_iclr ? wr_data[EV_W-1:0] : '0));
      if (wr_ien) begin
        int_enable <= wr_data[EV_W-1:0];
      end
      irq <= |(int_status & int_enable);
    end
  end

  // --------------------------------------------------------------
  // Read data, one cycle after the strobe
  // --------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !rd_en) begin
      rd_data <= '0;
    end else begin
      unique case (1'b1)
        hit(addr, OFS_RX_BUF):      rd_data <= DATA_W'(head.data & {8{count != '0}});
        hit(addr, OFS_FIFO_CTRL):   rd_data <= DATA_W'(fifo_en);
        hit(addr, OFS_LINE_CTRL):   rd_data <= DATA_W'(line_ctrl);
        hit(addr, OFS_LINE_STATUS): rd_data <= DATA_W'(line_status);
        hit(addr, OFS_SCRATCH):     rd_data <= DATA_W'(scratch_pad);
        hit(addr, OFS_INT_STATUS):  rd_data <= DATA_W'(int_status);
        hit(addr, OFS_INT_ENABLE):  rd_data <= DATA_W'(int_enable);
        default:                    rd_data <= '0;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  frm_head_a: assert property (head_load && head.frm |=> framing_error_flag)
    else $error("framing flag not set from head");
  frm_clear_a: assert property (rd_lsr && !head_load |=> !framing_error_flag)
    else $error("framing flag not cleared by read");
  resync_a: assert property (stop_tick && !rx_s && !rx_zero
    |=> rx_state == ULS_RX_DATA && rx_idx == 3'h0 && rx_cnt == '0)
    else $error("no resync on bad stop bit");
  head_only_a: assert property (!head_load && !rd_lsr |=> $stable(framing_error_flag))
    else $error("framing flag moved without head change");
  brk_det_a: assert property (stop_tick && !rx_s && rx_zero
    |=> rx_push && rx_entry.brk && rx_state == ULS_RX_BRK)
    else $error("break not detected");
  brk_idle_a: assert property (rx_state == ULS_RX_BRK && !rx_s
    |=> rx_state == ULS_RX_BRK && !rx_push)
    else $error("receiver left break while line low");
  brk_clear_a: assert property (rd_lsr && !head_load |=> !break_detect_flag)
    else $error("break flag not cleared by read");
  hold_wr_a: assert property (wr_thr |=> !line_status[LSR_HOLD_EMPTY])
    else $error("holding empty after write");
  idle_busy_a: assert property (tx_load |=> !line_status[LSR_TX_IDLE] [*2])
    else $error("transmitter idle while shifting");
  ferr_set_a: assert property (do_push && has_err(rx_entry) && !wr_fcr
    |=> rx_fifo_error_flag)
    else $error("fifo error not set");
  ferr_hold_a: assert property (rd_lsr && err_cnt != '0 && rx_fifo_error_flag && !wr_fcr
    |=> rx_fifo_error_flag)
    else $error("fifo error cleared with errors left");
  ferr_mask_a: assert property (rd_lsr && !fifo_en |=> !rd_data[LSR_FIFO_ERR])
    else $error("fifo error visible while disabled");
  scr_rw_a: assert property (wr_scr ##1 !wr_scr ##1 rd_en && hit(addr, OFS_SCRATCH)
    |=> rd_data[7:0] == $past(wr_data[7:0], 3))
    else $error("scratch readback mismatch");
  ready_read_a: assert property (rd_lsr |=> rd_data[LSR_READY] == ($past(count) != '0))
    else $error("data ready wrong");
  lsr_wr_a: assert property (wr_lsr && !head_load |=> $stable(break_detect_flag))
    else $error("status write changed a flag");

  brk_c: cover property (rx_state == ULS_RX_BRK ##[1:1000] rx_state == ULS_RX_IDLE);
  resync_c: cover property (stop_tick && !rx_s && !rx_zero);
  tx_done_c: cover property ($fell(tx_busy) && !thr_full);
  irq_c: cover property ($rose(irq));
endmodule

// File: verif/uls_remote.sv
// Remote serial partner: transmits frames and breaks, decodes received frames
`timescale 1ns/1ps
module uls_remote #(
  parameter int BIT_CYC = 8
) (
  // Clock
  input  wire logic clk,
  // Serial lines
  output logic      rx_line,
  input  wire logic tx_line
);
  logic [7:0] rx_q[$];
  logic [7:0] rx_b;
  logic [9:0] bits;

  initial begin
    rx_line = 1'b1;
  end

  // ---------------------------------------------------------------
  // Transmit side
  // ---------------------------------------------------------------
  // Stop low makes a framing fault; line is marking again afterwards
  task automatic send_char(input logic [7:0] v, input logic stop);
    bits = {stop, v, 1'b0};
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      rx_line <= bits[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    rx_line <= 1'b1;
  endtask

  task automatic send_break(input int nbits);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (nbits * BIT_CYC) @(posedge clk);
    rx_line <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Receive side
  // ---------------------------------------------------------------
  // Samples mid-bit; stop bit is not checked, only the data is kept
  always begin
    @(negedge tx_line);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      rx_b[i] = tx_line;
    end
    repeat (BIT_CYC) @(posedge clk);
    rx_q.push_back(rx_b);
  end
endmodule

// File: verif/tb_uls_top.sv
// Self-checking bench for the line status and scratch block
`timescale 1ns/1ps
module tb_uls_top;
  import uls_pkg::*;
  localparam int BC = 8;
  logic        clk;
  logic        resetn;
  logic [31:0] addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        serial_rx_pin;
  logic        serial_tx_pin;
  logic        irq;
  int          num_errors;
  int          n_compared;
  logic [7:0]  d;
  logic [7:0]  d2;
  logic [7:0]  rnd[3];

  uls_top #(.BIT_CYC(BC), .FIFO_DEPTH(16)) u_dut (
    .clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .irq(irq));

  uls_remote #(.BIT_CYC(BC)) u_remote (
    .clk(clk), .rx_line(serial_rx_pin), .tx_line(serial_tx_pin));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lsr_v(input logic ready, input logic frm, input logic brk,
                                        input logic ferr, input logic hold_mt = 1'b1,
                                        input logic idle = 1'b1);
    logic [31:0] v;
    v = 32'h0;
    v[LSR_READY] = ready;
    v[LSR_FRAMING] = frm;
    v[LSR_BREAK] = brk;
    v[LSR_HOLD_EMPTY] = hold_mt;
    v[LSR_TX_IDLE] = idle;
    v[LSR_FIFO_ERR] = ferr;
    return v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask

  // Registered irq lags its cause by one cycle
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic report_and_stop;
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 32'h0;
    wr_data = 32'h0;
    num_errors = 0;
    n_compared = 0;
    void'($urandom(32'h8d3555e1));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    rd(OFS_SCRATCH, 32'h0);
    rd(32'he000c0fc, 32'h0);
    wr(OFS_INT_ENABLE, 32'hf);
    d = 8'($urandom);
    wr(OFS_SCRATCH, {24'h0, d});
    rd(OFS_SCRATCH, {24'h0, d});
    wr(OFS_LINE_STATUS, 32'hff);
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    irq_is(1'b0);
    // Transmit: second byte waits in holding while the first shifts out
    wr(OFS_INT_ENABLE, 32'h8);
    d = 8'($urandom);
    d2 = 8'($urandom);
    wr(OFS_TX_HOLD, {24'h0, d});
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0, 1, 0));
    wr(OFS_TX_HOLD, {24'h0, d2});
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0, 0, 0));
    wr(OFS_INT_CLEAR, 32'hf);
    irq_is(1'b0);
    repeat (11 * BC) @(posedge clk);
    irq_is(1'b1);
    wr(OFS_INT_ENABLE, 32'h0);
    irq_is(1'b0);
    wr(OFS_INT_ENABLE, 32'h8);
    irq_is(1'b1);
    wr(OFS_INT_CLEAR, 32'h8);
    irq_is(1'b0);
    repeat (12 * BC) @(posedge clk);
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    chk(32'(u_remote.rx_q.size()), 32'h2);
    chk({24'h0, u_remote.rx_q.pop_front()}, {24'h0, d});
    chk({24'h0, u_remote.rx_q.pop_front()}, {24'h0, d2});
    // Receive, FIFO off: good char, then framing fault with depth one
    d = 8'($urandom);
    u_remote.send_char(d, 1'b1);
    repeat (BC) @(posedge clk);
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 0));
    rd(OFS_RX_BUF, {24'h0, d});
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    d = 8'($urandom) | 8'h01;
    u_remote.send_char(d, 1'b0);
    repeat (12 * BC) @(posedge clk);
    rd(OFS_LINE_STATUS, lsr_v(1, 1, 0, 0));
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 0));
    rd(OFS_RX_BUF, {24'h0, d});
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    // FIFO on: low stop is taken as the start of an all-ones char
    wr(OFS_FIFO_CTRL, 32'h1);
    u_remote.send_char(d, 1'b0);
    repeat (12 * BC) @(posedge clk);
    rd(OFS_LINE_STATUS, lsr_v(1, 1, 0, 1));
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 1));
    rd(OFS_RX_BUF, {24'h0, d});
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 1));
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 0));
    rd(OFS_RX_BUF, 32'hff);
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    // Break over two char times yields one char only
    u_remote.send_break(20);
    repeat (2 * BC) @(posedge clk);
    rd(OFS_LINE_STATUS, lsr_v(1, 1, 1, 1));
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 1));
    rd(OFS_RX_BUF, 32'h0);
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 1));
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    // Random bytes queue up in order
    for (int i = 0; i < 3; i++) begin
      rnd[i] = 8'($urandom);
      u_remote.send_char(rnd[i], 1'b1);
    end
    repeat (BC) @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 0));
      rd(OFS_RX_BUF, {24'h0, rnd[i]});
    end
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    // Odd parity on: odd-weight byte meets the high stop slot of its 8N1 frame as parity
    wr(OFS_LINE_CTRL, 32'h1);
    d = 8'($urandom);
    d[7] = ~^d[6:0];
    u_remote.send_char(d, 1'b1);
    repeat (2 * BC) @(posedge clk);
    rd(OFS_LINE_STATUS, lsr_v(1, 0, 0, 1) | (32'h1 << LSR_PE));
    rd(OFS_RX_BUF, {24'h0, d});
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 1));
    wr(OFS_LINE_CTRL, 32'h0);
    wr(OFS_FIFO_CTRL, 32'h0);
    rd(OFS_LINE_STATUS, lsr_v(0, 0, 0, 0));
    report_and_stop();
  end
endmodule
